// ---- core/rdls_serializer.sv ----
// transmit side: pixel capture, colour correction, dithering, lane serializer, config port
`timescale 1ns/1ps
`include "rdls_params.svh"
module rdls_serializer #(
  parameter int LINE_MAX = `RDLS_LINE_MAX,
  parameter int ROW_MAX  = `RDLS_ROW_MAX
) (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       pixel_clk,
  input  wire logic [7:0] red,
  input  wire logic [7:0] green,
  input  wire logic [7:0] blue,
  input  wire logic       frame_sync,
  input  wire logic       pixel_valid,
  input  wire logic       cfg_port_select_n,
  input  wire logic       cfg_shift_clk,
  input  wire logic       cfg_data_or_line_sync_i,
  output logic            cfg_data_or_line_sync_o,
  output logic            cfg_data_or_line_sync_oe,
  input  wire logic       sleep_n,
  input  wire logic       test_select,
  output logic [2:0]      serial_data_lanes,
  output logic            serial_clock_lane,
  output logic            pclk_stopped,
  output logic            lut_enabled
);
  localparam int STOP_CYC = `RDLS_PCLK_STOP_CYC;
  localparam int SW       = 32;
  localparam int BITS     = `RDLS_LANE_BITS;

  // two-flop synchronisers for every pin; only stage two is read
  logic [SW-1:0] sync1_q, sync2_q;
  logic [7:0]    s_red, s_green, s_blue;
  logic          s_pclk, s_fs, s_pv, s_csn, s_sck, s_sda, s_sleep_n, s_test;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else
    begin
      sync1_q <= {test_select, sleep_n, cfg_data_or_line_sync_i, cfg_shift_clk,
                  cfg_port_select_n, pixel_valid, frame_sync, blue, green, red, pixel_clk};
      sync2_q <= sync1_q;
    end
  end
  assign {s_test, s_sleep_n, s_sda, s_sck, s_csn, s_pv, s_fs, s_blue, s_green, s_red, s_pclk} =
         sync2_q;

  // pixel clock edge finder and stop detector
  logic                   pclk_prev_q, pclk_prev_d, sck_prev_q, sck_prev_d;
  logic [`RDLS_STOP_W-1:0] stop_cnt_q, stop_cnt_d;
  logic                   pclk_rise, pclk_static, clk_stop_err, sck_rise, sck_fall;

  always_comb
  begin
    // held high while asleep, so a pin already high at wake-up is not taken for a rise
    pclk_prev_d = s_sleep_n ? s_pclk : 1'b1;
    sck_prev_d  = s_sck;
    stop_cnt_d  = stop_cnt_q;
    if (s_pclk != pclk_prev_q)
      stop_cnt_d = '0;
    else if (stop_cnt_q != `RDLS_STOP_W'(STOP_CYC))
      stop_cnt_d = stop_cnt_q + `RDLS_STOP_W'(1);
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pclk_prev_q <= 1'b0;
      sck_prev_q  <= 1'b0;
      stop_cnt_q  <= '0;
    end
    else
    begin
      pclk_prev_q <= pclk_prev_d;
      sck_prev_q  <= sck_prev_d;
      stop_cnt_q  <= stop_cnt_d;
    end
  end
  assign pclk_rise    = s_pclk & ~pclk_prev_q;
  assign pclk_static  = (stop_cnt_q == `RDLS_STOP_W'(STOP_CYC));
  assign clk_stop_err = (stop_cnt_d == `RDLS_STOP_W'(STOP_CYC)) && !pclk_static;
  assign sck_rise     = s_sck & ~sck_prev_q;
  assign sck_fall     = ~s_sck & sck_prev_q;
  assign pclk_stopped = pclk_static;

  // configuration port: 8-bit command, 8-bit address, 8-bit data, msb first
  rdls_pkg::rdls_cfg_state_t cfg_st_q, cfg_st_d;
  logic [22:0] cfg_sr_q, cfg_sr_d;
  logic [4:0]  cfg_cnt_q, cfg_cnt_d;
  logic [7:0]  rd_sh_q, rd_sh_d, ctrl_q, ctrl_d;
  logic        rd_first_q, rd_first_d, cfg_active, lut_we;
  logic [23:0] nb;
  logic [1:0]  lut_idx;
  logic [7:0]  lut_q [`RDLS_LANES][`RDLS_LUT_DEPTH];

  assign cfg_active = ~s_csn & s_sleep_n & pclk_static;
  assign nb         = {cfg_sr_q, s_sda};
  assign lut_idx    = nb[17:16] - 2'h1;

  always_comb
  begin
    cfg_st_d   = cfg_st_q;
    cfg_sr_d   = cfg_sr_q;
    cfg_cnt_d  = cfg_cnt_q;
    rd_sh_d    = rd_sh_q;
    rd_first_d = rd_first_q;
    ctrl_d     = ctrl_q;
    lut_we     = 1'b0;
    unique case (cfg_st_q)
      rdls_pkg::CFG_IDLE:
      begin
        cfg_cnt_d = '0;
        if (cfg_active)
          cfg_st_d = rdls_pkg::CFG_SHIFT;
      end
      rdls_pkg::CFG_SHIFT:
      begin
        if (sck_rise)
        begin
          cfg_sr_d  = nb[22:0];
          cfg_cnt_d = cfg_cnt_q + 5'h01;
          if (cfg_cnt_q == 5'(`RDLS_HDR_BITS - 1) && nb[8 + `RDLS_CMD_RW_BIT])
          begin
            cfg_st_d   = rdls_pkg::CFG_READ;
            rd_first_d = 1'b1;
            rd_sh_d    = (nb[9:8] == `RDLS_TGT_CTRL) ? ctrl_q : lut_q[nb[9:8] - 2'h1][nb[7:0]];
          end
          else if (cfg_cnt_q == 5'(`RDLS_FRAME_BITS - 1))
          begin
            cfg_st_d = rdls_pkg::CFG_DONE;
            if (nb[17:16] == `RDLS_TGT_CTRL)
              ctrl_d = nb[7:0];
            else
              lut_we = 1'b1;
          end
        end
      end
      rdls_pkg::CFG_READ:
      begin
        if (sck_fall)
        begin
          rd_first_d = 1'b0;
          if (!rd_first_q)
            rd_sh_d = {rd_sh_q[6:0], 1'b0};
        end
      end
      rdls_pkg::CFG_DONE:
        cfg_st_d = rdls_pkg::CFG_DONE;
    endcase
    if (!cfg_active)
      cfg_st_d = rdls_pkg::CFG_IDLE;
    if (!s_sleep_n)
      ctrl_d = `RDLS_CTRL_RST;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cfg_st_q   <= rdls_pkg::CFG_IDLE;
      cfg_sr_q   <= '0;
      cfg_cnt_q  <= '0;
      rd_sh_q    <= '0;
      rd_first_q <= 1'b0;
      ctrl_q     <= `RDLS_CTRL_RST;
    end
    else
    begin
      cfg_st_q   <= cfg_st_d;
      cfg_sr_q   <= cfg_sr_d;
      cfg_cnt_q  <= cfg_cnt_d;
      rd_sh_q    <= rd_sh_d;
      rd_first_q <= rd_first_d;
      ctrl_q     <= ctrl_d;
    end
  end

  // table contents have no reset so they survive sleep
  always_ff @(posedge clk)
  begin
    if (lut_we)
      lut_q[lut_idx][nb[15:8]] <= nb[7:0];
  end

  assign cfg_data_or_line_sync_oe = (cfg_st_q == rdls_pkg::CFG_READ);
  assign cfg_data_or_line_sync_o  = rd_sh_q[7];
  assign lut_enabled              = ctrl_q[`RDLS_CTRL_LUT_EN];

  // pixel capture
  rdls_pkg::rdls_pixel_t cap_q, cap_d;
  logic                  cap_v_q, cap_v_d;

  always_comb
  begin
    cap_v_d = pclk_rise & s_sleep_n;
    cap_d   = cap_q;
    if (pclk_rise)
    begin
      cap_d.frame_sync  = s_fs;
      cap_d.line_sync   = s_csn ? s_sda : 1'b0;
      cap_d.pixel_valid = s_pv;
      cap_d.red         = s_red;
      cap_d.green       = s_green;
      cap_d.blue        = s_blue;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cap_q   <= '0;
      cap_v_q <= 1'b0;
    end
    else
    begin
      cap_q   <= cap_d;
      cap_v_q <= cap_v_d;
    end
  end

  // correction and ordered dither
  function automatic logic [5:0] rdls_dither(input logic [7:0] v, input logic [1:0] t);
    logic [8:0] s;
    s = {1'b0, v} + {7'h00, t};
    rdls_dither = s[8] ? 6'h3F : s[7:2];
  endfunction : rdls_dither

  function automatic logic [1:0] rdls_bayer(input logic [1:0] yx);
    logic [1:0] r;
    r = 2'h0;
    unique case (yx)
      2'h0: r = 2'h0;
      2'h1: r = 2'h2;
      2'h2: r = 2'h3;
      2'h3: r = 2'h1;
    endcase
    rdls_bayer = r;
  endfunction : rdls_bayer

  logic [9:0]             x_q, x_d, px;
  logic [8:0]             y_q, y_d, py;
  logic [1:0]             frm_q, frm_d, thr;
  logic                   fs_prev_q, ls_prev_q, fs_rise, ls_rise, stall, err, buf_in_ready;
  logic [`RDLS_SEQ_W-1:0] seq_q, seq_d;
  logic [7:0]             corr_r, corr_g, corr_b;
  rdls_pkg::rdls_word_t   word_q, word_d;
  logic                   word_v_q, word_v_d;

  assign fs_rise = cap_q.frame_sync & ~fs_prev_q;
  assign ls_rise = cap_q.line_sync & ~ls_prev_q;
  assign stall   = word_v_q & ~buf_in_ready;
  assign err     = (cap_v_q & stall) | clk_stop_err;
  assign corr_r  = lut_enabled ? lut_q[0][cap_q.red] : cap_q.red;
  assign corr_g  = lut_enabled ? lut_q[1][cap_q.green] : cap_q.green;
  assign corr_b  = lut_enabled ? lut_q[2][cap_q.blue] : cap_q.blue;
  assign px      = (fs_rise | ls_rise) ? 10'h000 : x_q;
  assign py      = fs_rise ? 9'h000 : (ls_rise && y_q != 9'(ROW_MAX - 1)) ? y_q + 9'h001 : y_q;
  assign frm_d   = (cap_v_q & fs_rise) ? frm_q + 2'h1 : frm_q;
  assign thr     = rdls_bayer({py[0], px[0]}) + frm_d;

  always_comb
  begin
    x_d      = x_q;
    y_d      = y_q;
    word_d   = word_q;
    word_v_d = word_v_q & ~buf_in_ready;
    seq_d    = seq_q;
    if (cap_v_q)
    begin
      y_d = py;
      x_d = (cap_q.pixel_valid && px != 10'(LINE_MAX - 1)) ? px + 10'h001 : px;
      if (!stall)
      begin
        word_v_d        = 1'b1;
        word_d.lanes[0] = {cap_q.frame_sync,
                           cap_q.pixel_valid ? rdls_dither(corr_r, thr) : seq_q};
        word_d.lanes[1] = {cap_q.line_sync, rdls_dither(corr_g, thr)};
        word_d.lanes[2] = {cap_q.pixel_valid, rdls_dither(corr_b, thr)};
        if (!cap_q.pixel_valid)
          seq_d = seq_q + `RDLS_SEQ_W'(1);
      end
    end
    if (err || (cap_v_q && fs_rise))
      seq_d = '0;
    if (!s_sleep_n)
      word_v_d = 1'b0;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      x_q       <= '0;
      y_q       <= '0;
      frm_q     <= '0;
      fs_prev_q <= 1'b0;
      ls_prev_q <= 1'b0;
      seq_q     <= '0;
      word_q    <= '0;
      word_v_q  <= 1'b0;
    end
    else
    begin
      x_q       <= x_d;
      y_q       <= y_d;
      frm_q     <= frm_d;
      fs_prev_q <= cap_v_q ? cap_q.frame_sync : fs_prev_q;
      ls_prev_q <= cap_v_q ? cap_q.line_sync : ls_prev_q;
      seq_q     <= seq_d;
      word_q    <= word_d;
      word_v_q  <= word_v_d;
    end
  end

  // two-entry buffer absorbs one word of lane back-pressure
  rdls_pkg::rdls_word_t buf_out_data;
  logic                 buf_out_valid, buf_out_ready;

  rdls_skid_buf #(
    .WIDTH ($bits(rdls_pkg::rdls_word_t)),
    .DEPTH (`RDLS_BUF_DEPTH)
  ) u_buf (
    .clk       (clk),
    .arst_n    (arst_n),
    .in_valid  (word_v_q),
    .in_data   (word_q),
    .in_ready  (buf_in_ready),
    .out_valid (buf_out_valid),
    .out_ready (buf_out_ready),
    .out_data  (buf_out_data)
  );

  // lane shifter: seven bits per lane, clock lane toggles once per bit
  rdls_pkg::rdls_link_state_t link_st_q, link_st_d;
  rdls_pkg::rdls_word_t       sh_q, sh_d;
  logic [2:0]                 bit_q, bit_d, lanes_q, lanes_d;
  logic                       ck_q, ck_d, link_en, load;

  assign link_en = s_sleep_n & ~s_test & ~(ctrl_q[`RDLS_CTRL_AUTO_PD] & pclk_static);
  assign buf_out_ready = (link_st_q == rdls_pkg::LINK_IDLE) | ~link_en;
  assign load = link_en & (link_st_q == rdls_pkg::LINK_IDLE) & buf_out_valid;

  always_comb
  begin
    link_st_d = link_st_q;
    sh_d      = sh_q;
    bit_d     = bit_q;
    lanes_d   = 3'h0;
    ck_d      = 1'b0;
    unique case (link_st_q)
      rdls_pkg::LINK_IDLE:
      begin
        if (load)
        begin
          link_st_d = rdls_pkg::LINK_SEND;
          bit_d     = 3'h0;
          ck_d      = 1'b1;
          for (int k = 0; k < `RDLS_LANES; k++)
          begin
            lanes_d[k]    = buf_out_data.lanes[k][BITS-1];
            sh_d.lanes[k] = {buf_out_data.lanes[k][BITS-2:0], 1'b0};
          end
        end
      end
      rdls_pkg::LINK_SEND:
      begin
        if (bit_q == 3'(BITS - 1))
          link_st_d = rdls_pkg::LINK_IDLE;
        else
        begin
          bit_d = bit_q + 3'h1;
          ck_d  = ~ck_q;
          for (int k = 0; k < `RDLS_LANES; k++)
          begin
            lanes_d[k]    = sh_q.lanes[k][BITS-1];
            sh_d.lanes[k] = {sh_q.lanes[k][BITS-2:0], 1'b0};
          end
        end
      end
    endcase
    if (!link_en)
    begin
      link_st_d = rdls_pkg::LINK_IDLE;
      lanes_d   = 3'h0;
      ck_d      = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      link_st_q <= rdls_pkg::LINK_IDLE;
      sh_q      <= '0;
      bit_q     <= '0;
      lanes_q   <= '0;
      ck_q      <= 1'b0;
    end
    else
    begin
      link_st_q <= link_st_d;
      sh_q      <= sh_d;
      bit_q     <= bit_d;
      lanes_q   <= lanes_d;
      ck_q      <= ck_d;
    end
  end
  assign serial_data_lanes = lanes_q;
  assign serial_clock_lane = ck_q;

  a_oe_only_selected: assert property (@(posedge clk) disable iff (!arst_n)
    cfg_data_or_line_sync_oe |-> $past(!s_csn && s_sleep_n && pclk_static))
    else $error("config pin driven outside a selected read");

  a_sleep_clears_ctrl: assert property (@(posedge clk) disable iff (!arst_n)
    !s_sleep_n |=> ctrl_q == `RDLS_CTRL_RST && cfg_st_q == rdls_pkg::CFG_IDLE)
    else $error("sleep did not reset config state");

  a_capture_on_rise: assert property (@(posedge clk) disable iff (!arst_n)
    cap_v_q |-> $past(s_pclk) && !$past(pclk_prev_q) && cap_q.red == $past(s_red))
    else $error("capture not tied to pixel clock rise");

  a_dither_floor: assert property (@(posedge clk) disable iff (!arst_n)
    cap_v_q && !stall && cap_q.pixel_valid |=> word_q.lanes[1][5:0] >= $past(corr_g[7:2]))
    else $error("dithered green below truncated value");

  a_frame_restart: assert property (@(posedge clk) disable iff (!arst_n)
    cap_v_q && fs_rise |=> y_q == 9'h000 && x_q <= 10'h001 && seq_q == '0)
    else $error("pattern not restarted at frame start");

  a_sync_forwarded: assert property (@(posedge clk) disable iff (!arst_n)
    cap_v_q && !stall |=> word_v_q && word_q.lanes[0][6] == $past(cap_q.frame_sync))
    else $error("frame sync altered in word");

  a_clock_lane_runs: assert property (@(posedge clk) disable iff (!arst_n)
    load |=> serial_clock_lane ##1 !serial_clock_lane ##1 serial_clock_lane || !link_en)
    else $error("clock lane not toggling per bit");

  a_link_down_idle: assert property (@(posedge clk) disable iff (!arst_n)
    !link_en |=> serial_data_lanes == 3'h0 && !serial_clock_lane)
    else $error("lanes active while link down");

  a_error_resync: assert property (@(posedge clk) disable iff (!arst_n)
    err |=> seq_q == '0)
    else $error("sequence bits not resynchronised");

endmodule : rdls_serializer

// ---- core/rdls_params.svh ----
// constants for the rgb dither, correction table and serial link block
`ifndef RDLS_PARAMS_SVH
`define RDLS_PARAMS_SVH

`define RDLS_CLK_PERIOD_NS 25
`define RDLS_PCLK_STOP_NS  1000
`define RDLS_PCLK_STOP_CYC ((`RDLS_PCLK_STOP_NS + `RDLS_CLK_PERIOD_NS - 1) / `RDLS_CLK_PERIOD_NS)
`define RDLS_STOP_W        8
`define RDLS_LINE_MAX      640
`define RDLS_ROW_MAX       480
`define RDLS_LUT_DEPTH     256
`define RDLS_LANES         3
`define RDLS_LANE_BITS     7
`define RDLS_SEQ_W         6
`define RDLS_FRAME_BITS    24
`define RDLS_HDR_BITS      16
`define RDLS_CMD_RW_BIT    7
`define RDLS_TGT_CTRL      2'h0
`define RDLS_CTRL_LUT_EN   0
`define RDLS_CTRL_AUTO_PD  1
`define RDLS_CTRL_RST      8'h00
`define RDLS_BUF_DEPTH     2

`endif

// ---- core/rdls_pkg.sv ----
// types shared by the rgb dither, correction table and serial link block
package rdls_pkg;

  typedef struct packed {
    logic       frame_sync;
    logic       line_sync;
    logic       pixel_valid;
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } rdls_pixel_t;

  // lane k carries {control bit, six colour bits} (lane 0 six sequence bits when pixel_valid is low), msb sent first
  typedef struct packed {
    logic [2:0][6:0] lanes;
  } rdls_word_t;

  typedef enum logic [1:0] {
    CFG_IDLE  = 2'b00,
    CFG_SHIFT = 2'b01,
    CFG_READ  = 2'b10,
    CFG_DONE  = 2'b11
  } rdls_cfg_state_t;

  typedef enum logic {
    LINK_IDLE = 1'b0,
    LINK_SEND = 1'b1
  } rdls_link_state_t;

endpackage : rdls_pkg

// ---- core/rdls_skid_buf.sv ----
// small fifo between the dither stage and the lane shifter
`timescale 1ns/1ps
module rdls_skid_buf #(
  parameter int WIDTH = 21,
  parameter int DEPTH = 2
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [CW-1:0]    cnt_q, cnt_d;
  logic             push, pop;

  assign in_ready  = (cnt_q != CW'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb
  begin
    wr_d  = push ? ((wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + PW'(1)) : wr_q;
    rd_d  = pop ? ((rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + PW'(1)) : rd_q;
    cnt_d = cnt_q + CW'(push) - CW'(pop);
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // payload storage needs no reset, occupancy guards it
  always_ff @(posedge clk)
  begin
    if (push)
      mem_q[wr_q] <= in_data;
  end

  a_buf_count_up: assert property (@(posedge clk) disable iff (!arst_n)
    push && !pop |=> cnt_q == $past(cnt_q) + CW'(1))
    else $error("buffer count did not rise on push");

  a_buf_order: assert property (@(posedge clk) disable iff (!arst_n)
    push && cnt_q == '0 && !pop |=> out_valid && out_data == $past(in_data))
    else $error("buffer head does not match first word");

endmodule : rdls_skid_buf

// ---- test/rdls_lane_rx.sv ----
// behavioural remote deserializer: rebuilds lane words from clock lane edges
`timescale 1ns/1ps
module rdls_lane_rx (
  input  wire logic            clk,
  input  wire logic            arst_n,
  input  wire logic [2:0]      serial_data_lanes,
  input  wire logic            serial_clock_lane,
  output rdls_pkg::rdls_word_t word_q,
  output logic [15:0]          count_q
);
  rdls_pkg::rdls_word_t sh_q;
  rdls_pkg::rdls_word_t sh_d;
  logic [2:0]           idx_q;
  logic                 lck_q;

  always_comb
  begin
    for (int k = 0; k < 3; k++)
      sh_d.lanes[k] = {sh_q.lanes[k][5:0], serial_data_lanes[k]};
  end

  // each clock lane change carries one bit, the trailing fall carries none
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sh_q    <= '0;
      word_q  <= '0;
      count_q <= 16'h0000;
      idx_q   <= 3'h0;
      lck_q   <= 1'b0;
    end
    else
    begin
      lck_q <= serial_clock_lane;
      if (serial_clock_lane != lck_q)
      begin
        if (idx_q == 3'h7)
          idx_q <= 3'h0;
        else
        begin
          sh_q <= sh_d;
          idx_q <= idx_q + 3'h1;
          if (idx_q == 3'h6)
          begin
            word_q  <= sh_d;
            count_q <= count_q + 16'h0001;
          end
        end
      end
    end
  end
endmodule : rdls_lane_rx

// ---- test/tb_top.sv ----
// directed testbench for the pixel serializer
`timescale 1ns/1ps
module tb_top;
  logic                 clk, arst_n, pixel_clk, frame_sync, pixel_valid;
  logic [7:0]           red, green, blue, rd;
  logic                 sel_n, sclk, host_bit, host_en, sleep_n, test_select;
  logic                 pin_o, pin_oe, pin_i, lane_clk, pclk_stopped, lut_enabled;
  logic [2:0]           lanes;
  logic [15:0]          rx_count, seen_cnt;
  rdls_pkg::rdls_word_t rx_word, w, w2;
  rdls_pkg::rdls_word_t rx_q[$];
  int                   miscompares, tests_run, n;

  // released pin shows a changing level rather than a stale one
  assign pin_i = pin_oe ? pin_o : (host_en ? host_bit : ~pin_o);

  rdls_serializer rdls_serializer_inst (.clk(clk), .arst_n(arst_n), .pixel_clk(pixel_clk),
    .red(red), .green(green), .blue(blue), .frame_sync(frame_sync),
    .pixel_valid(pixel_valid), .cfg_port_select_n(sel_n), .cfg_shift_clk(sclk),
    .cfg_data_or_line_sync_i(pin_i), .cfg_data_or_line_sync_o(pin_o),
    .cfg_data_or_line_sync_oe(pin_oe), .sleep_n(sleep_n), .test_select(test_select),
    .serial_data_lanes(lanes), .serial_clock_lane(lane_clk),
    .pclk_stopped(pclk_stopped), .lut_enabled(lut_enabled));

  rdls_lane_rx rdls_lane_rx_inst (.clk(clk), .arst_n(arst_n), .serial_data_lanes(lanes),
    .serial_clock_lane(lane_clk), .word_q(rx_word), .count_q(rx_count));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk)
    if (rx_count !== seen_cnt)
    begin
      rx_q.push_back(rx_word);
      seen_cnt = rx_count;
    end

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask : cyc

  task automatic finish_test();
    $display("compares %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finish_test

  task automatic check(input string nm, input logic [7:0] exp, input logic [7:0] seen);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic check_rng(input string nm, input logic [7:0] lo, hi, seen);
    tests_run++;
    if ((seen >= lo) !== 1'b1 || (seen <= hi) !== 1'b1)
    begin
      miscompares++;
      $display("[ERR] %s expected %h..%h seen %h", nm, lo, hi, seen);
    end
  endtask : check_rng

  // one pixel clock period of 8 clk, the sustainable rate
  task automatic pix(input logic [7:0] r, g, b, input logic fs, ls, dv);
    red <= r;
    green <= g;
    blue <= b;
    frame_sync <= fs;
    host_bit <= ls;
    pixel_valid <= dv;
    pixel_clk <= 1'b0;
    cyc(4);
    pixel_clk <= 1'b1;
    cyc(4);
  endtask : pix

  task automatic get_word(output rdls_pkg::rdls_word_t wd);
    int k;
    k = 0;
    while (rx_q.size() == 0 && k < 60)
    begin
      cyc(1);
      k++;
    end
    if (rx_q.size() == 0)
    begin
      miscompares++;
      finish_test();
    end
    else
      wd = rx_q.pop_front();
  endtask : get_word

  // frame of 24 bits; a read releases the pin after the first 16
  task automatic cfg(input logic sel, input logic [23:0] f, output logic [7:0] q);
    sel_n <= sel;
    cyc(48);
    for (int i = 0; i < 24; i++)
    begin
      host_bit <= f[23-i];
      host_en <= !(f[23] && i >= 16);
      cyc(6);
      if (i == 16 && !sel)
        check("pin_oe", {7'h00, f[23]}, {7'h00, pin_oe});
      if (i >= 16)
        q[23-i] = pin_i;
      sclk <= 1'b1;
      cyc(6);
      sclk <= 1'b0;
    end
    cyc(6);
    sel_n <= 1'b1;
    host_en <= 1'b1;
    host_bit <= 1'b0;
    cyc(8);
  endtask : cfg

  task automatic check_pix(input rdls_pkg::rdls_word_t wd);
    check("red", 8'h3F, {2'b00, wd.lanes[0][5:0]});
    check_rng("green", 8'h00, 8'h01, {2'b00, wd.lanes[1][5:0]});
    check_rng("blue", 8'h20, 8'h21, {2'b00, wd.lanes[2][5:0]});
  endtask : check_pix

  function automatic logic [7:0] hdr(input rdls_pkg::rdls_word_t wd);
    hdr = {5'h00, wd.lanes[2][6], wd.lanes[1][6], wd.lanes[0][6]};
  endfunction : hdr

  initial
  begin
    {pixel_clk, sleep_n, sel_n, host_en} = 4'hF;
    {frame_sync, pixel_valid, sclk, host_bit} = 4'h0;
    test_select = 1'b0;
    {red, green, blue} = 24'h000000;
    {miscompares, tests_run, seen_cnt} = 0;
    arst_n = 1'b0;
    cyc(16);
    arst_n <= 1'b1;
    cyc(4);
    check("ctrl_reset", 8'h00, {7'h00, lut_enabled});
    check("pin_oe_idle", 8'h00, {7'h00, pin_oe});
    pix(8'hFF, 8'h00, 8'h80, 1'b1, 1'b0, 1'b1);
    get_word(w);
    check_pix(w);
    check("hdr", 8'h05, hdr(w));
    for (int i = 0; i < 4; i++)
      pix(8'hFF, 8'h00, 8'h80, i[0], i[1], 1'b1);
    for (int i = 0; i < 4; i++)
    begin
      get_word(w);
      check("burst_hdr", {6'h01, i[1:0]}, hdr(w));
    end
    pix(8'h00, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0);
    pix(8'h00, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0);
    n = 0;
    while (pclk_stopped !== 1'b1 && n < 80)
    begin
      cyc(1);
      n++;
    end
    check_rng("stop_time", 8'h20, 8'h2C, n[7:0]);
    if (n >= 80)
      finish_test();
    get_word(w);
    get_word(w2);
    check("seq_start", 8'h00, {2'b00, w.lanes[0][5:0]});
    check("seq_step", 8'h01, {2'b00, w2.lanes[0][5:0]});
    cfg(1'b0, 24'h000002, rd);
    cfg(1'b0, 24'h800000, rd);
    check("ctrl_read", 8'h02, rd);
    cfg(1'b0, 24'h0110FF, rd);
    cfg(1'b0, 24'h021000, rd);
    cfg(1'b0, 24'h031080, rd);
    cfg(1'b0, 24'h811000, rd);
    check("lut_read", 8'hFF, rd);
    cfg(1'b0, 24'h000001, rd);
    check("lut_en", 8'h01, {7'h00, lut_enabled});
    cfg(1'b1, 24'h000000, rd);
    check("sel_high", 8'h01, {7'h00, lut_enabled});
    pix(8'h10, 8'h10, 8'h10, 1'b0, 1'b0, 1'b1);
    get_word(w);
    check_pix(w);
    sleep_n <= 1'b0;
    cyc(8);
    check("sleep_ctrl", 8'h00, {7'h00, lut_enabled});
    sleep_n <= 1'b1;
    cyc(8);
    cfg(1'b0, 24'h000001, rd);
    pix(8'h10, 8'h10, 8'h10, 1'b0, 1'b0, 1'b1);
    get_word(w);
    check_pix(w);
    cfg(1'b0, 24'h000000, rd);
    pix(8'h10, 8'h10, 8'h10, 1'b0, 1'b0, 1'b1);
    get_word(w);
    check_rng("red_raw", 8'h04, 8'h05, {2'b00, w.lanes[0][5:0]});
    finish_test();
  end
endmodule : tb_top
